// *** sim/scs_comparator_model.sv ***
// Comparator partner model for the conversion sequencer.
// Assumes the trial pattern drives a code compared against a signed level.
`timescale 1ns/1ns
module scs_comparator_model (
  // Trial pattern and analog level.
  input  wire        [15:0] weights_in,
  input  wire signed [17:0] level_in,
  // Comparator decision.
  output wire               above_out
);
  // High when the trial code lies above the held input level.
  assign above_out = $signed({2'h0, weights_in})
                     > level_in;
endmodule // scs_comparator_model

// *** sim/scs_sequencer_monitor.sv ***
// Port checker for the conversion sequencer.
// Assumes it is bound to every scs_sequencer instance.
`timescale 1ns/1ns
module scs_sequencer_monitor #(parameter WIDTH = 16) (
  input wire             REF_CLK_IN,
  input wire             RST_N_IN,
  input wire             POSITIVE_ARRAY_GROUND_SWITCH_OUT,
  input wire             NEGATIVE_ARRAY_GROUND_SWITCH_OUT,
  input wire             ARRAY_TO_INPUT_OUT,
  input wire [WIDTH-1:0] TRIAL_WEIGHTS_OUT,
  input wire             POWER_UP_OUT,
  input wire             BUSY_OUT,
  input wire             DONE_STROBE_OUT,
  input wire [WIDTH-1:0] RESULT_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  strobe_single_a: assert property (
    DONE_STROBE_OUT |=> !DONE_STROBE_OUT)
    else $error("done strobe longer than one cycle");
  busy_end_a: assert property (
    $fell(BUSY_OUT) |-> DONE_STROBE_OUT)
    else $error("busy ended without strobe");
  result_hold_a: assert property (
    !DONE_STROBE_OUT |-> $stable(RESULT_OUT))
    else $error("result changed outside completion");
  idle_weights_a: assert property (
    !BUSY_OUT |-> TRIAL_WEIGHTS_OUT == 0)
    else $error("trial pattern outside conversion");
  open_switch_a: assert property (
    BUSY_OUT |-> !POSITIVE_ARRAY_GROUND_SWITCH_OUT
    && !NEGATIVE_ARRAY_GROUND_SWITCH_OUT)
    else $error("switch closed");
  hold_ground_a: assert property (
    $rose(BUSY_OUT) |-> ARRAY_TO_INPUT_OUT ##1 !ARRAY_TO_INPUT_OUT)
    else $error("arrays not grounded after opening");
  msb_first_a: assert property (
    $rose(BUSY_OUT) |-> ##2 TRIAL_WEIGHTS_OUT == 16'h8000)
    else $error("first trial not MSB");
  conv_length_a: assert property (
    $rose(BUSY_OUT) |-> ##51 DONE_STROBE_OUT)
    else $error("conversion not completed in time");
  power_down_a: assert property (
    !BUSY_OUT |-> !POWER_UP_OUT && ARRAY_TO_INPUT_OUT
    && POSITIVE_ARRAY_GROUND_SWITCH_OUT
    && NEGATIVE_ARRAY_GROUND_SWITCH_OUT)
    else $error("not back in acquisition");
endmodule // scs_sequencer_monitor
bind scs_sequencer scs_sequencer_monitor #(.WIDTH(WIDTH)) mon (.*);

// *** sim/test_scs_sequencer.sv ***
// Self-checking bench for the conversion sequencer.
// Assumes the comparator model stands on the analog side.
`timescale 1ns/1ns
module test_scs_sequencer;
  reg               clk = 1'b0;
  reg               rst_n = 1'b0;
  reg               convert_start_input = 1'b0;
  reg signed [17:0] level = 18'sd0;
  reg        [33:0] rows [0:7];
  wire              cmp, sp, sn, ati, pwr, busy, stb, viol;
  wire       [15:0] wts, res;
  integer           failures = 0;
  integer           n_checks = 0;
  integer           i, k;
  initial forever #2 clk = ~clk;
  scs_sequencer uut (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
    .CONVERT_START_INPUT_IN(convert_start_input), .COMPARATOR_IN(cmp),
    .POSITIVE_ARRAY_GROUND_SWITCH_OUT(sp),
    .NEGATIVE_ARRAY_GROUND_SWITCH_OUT(sn),
    .ARRAY_TO_INPUT_OUT(ati), .TRIAL_WEIGHTS_OUT(wts), .POWER_UP_OUT(pwr),
    .BUSY_OUT(busy), .DONE_STROBE_OUT(stb), .RESULT_OUT(res),
    .RATE_VIOLATION_OUT(viol));
  scs_comparator_model far (.weights_in(wts), .level_in(level),
    .above_out(cmp));
  task check(input [8*8-1:0] name, input [15:0] exp, input [15:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0s exp %h got %h", name, exp, got);
      end
    end
  endtask
  // Starts a conversion, toggles the convert input early in it, waits done.
  task convert;
    begin
      k = 0;
      @(negedge clk) convert_start_input = 1'b1;
      while (stb !== 1'b1 && k < 100) begin
        @(negedge clk) convert_start_input = (k > 5 && k < 20) ? k[1] : 1'b0;
        k = k + 1;
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #(4 * 20000);
    failures = failures + 1;
    give_verdict;
  end
  initial begin
    rows[0] = {18'sd0, 16'h0000};
    rows[1] = {18'sd32768, 16'h8000};
    rows[2] = {18'sd65535, 16'hFFFF};
    rows[3] = {18'sd32767, 16'h7FFF};
    rows[4] = {18'sd1, 16'h0001};
    rows[5] = {18'sd32769, 16'h8001};
    rows[6] = {18'sd70000, 16'hFFFF};
    rows[7] = {-18'sd5, 16'h0000};
    repeat (4) @(negedge clk);
    check("switch", 16'h0001, {15'h0000, sp & sn & ati});
    check("busy", 16'h0000, {13'h0000, busy, stb, pwr});
    rst_n = 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      level = rows[i][33:16];
      convert;
      check("strobe", 16'h0001, {15'h0000, stb});
      check("result", rows[i][15:0], res);
      check("busy", 16'h0000, {15'h0000, busy});
      repeat (1000) @(negedge clk);
      check("rate", 16'h0000, {15'h0000, viol});
    end
    level = 18'sd4660;
    convert;
    convert;
    check("result", 16'h1234, res);
    check("rate", 16'h0001, {15'h0000, viol});
    rst_n = 1'b0;
    @(negedge clk);
    check("rate", 16'h0000, {15'h0000, viol});
    check("result", 16'h0000, res);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    check("busy", 16'h0000, {15'h0000, busy});
    level = 18'sd43981;
    convert;
    check("result", 16'hABCD, res);
    check("rate", 16'h0000, {15'h0000, viol});
    give_verdict;
  end
endmodule // test_scs_sequencer

// *** src/scs_consts.vh ***
// Constants for the successive-approximation conversion sequencer.
// Assumes a 250 MHz reference clock; included by bare name.
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH
`define SCS_RES_BITS     16
`define SCS_CLK_MHZ      250
`define SCS_RATE_KSPS    250
`define SCS_PERIOD_CYC   16'h03E8
`define SCS_CODE_ZERO    16'h0000
`define SCS_CODE_MID     16'h8000
`define SCS_CODE_FULL    16'hFFFF
`define SCS_MSB_POS      4'hF
`define SCS_ST_ACQ       3'h0
`define SCS_ST_OPEN      3'h1
`define SCS_ST_HOLD      3'h2
`define SCS_ST_TRIAL     3'h3
`define SCS_ST_DECIDE    3'h4
`define SCS_ST_DONE      3'h5
`define SCS_ST_SETTLE    3'h6
`endif

// *** src/scs_sequencer.v ***
// Successive-approximation conversion sequencer for a 16-bit converter.
// Assumes the convert input and comparator come from outside the clock
// domain, and that the analog switch drivers follow the outputs directly.
//
// Function
// - A convert input rising edge ends acquisition and starts a conversion.
// - A conversion opens both ground switches, then grounds the arrays.
// - Sixteen trials run MSB first; the comparator keeps or clears each bit.
// - After the last trial, on one edge: power down, acquire, latch the code, flag done.
// - Timing comes from the on-chip clock and never from the serial clock.
// - Each result is of the sample at its own start, with no latency.
// - The result is straight binary from 0000 through 8000 to FFFF.
// - Over-range saturates at FFFF and under-range gives 0000 without wrap.
// - Conversions run at up to 250 kSPS with power-down between them; faster starts still run and set RATE_VIOLATION_OUT.
// - Once started, a conversion completes whatever the convert input does.
`timescale 1ns/1ns
`include "scs_consts.vh"
module scs_sequencer #(
  parameter WIDTH = `SCS_RES_BITS
) (
  // Clock and reset.
  input  wire             REF_CLK_IN,
  input  wire             RST_N_IN,
  // Host convert input and comparator.
  input  wire             CONVERT_START_INPUT_IN,
  input  wire             COMPARATOR_IN,
  // Analog switch control.
  output reg              POSITIVE_ARRAY_GROUND_SWITCH_OUT,
  output reg              NEGATIVE_ARRAY_GROUND_SWITCH_OUT,
  output reg              ARRAY_TO_INPUT_OUT,
  output reg  [WIDTH-1:0] TRIAL_WEIGHTS_OUT,
  output reg              POWER_UP_OUT,
  // Result to the serial output logic.
  output reg              BUSY_OUT,
  output reg              DONE_STROBE_OUT,
  output reg  [WIDTH-1:0] RESULT_OUT,
  output reg              RATE_VIOLATION_OUT
);

  // --------------------------------------------------------------------
  // Input synchronisers.
  // --------------------------------------------------------------------
  reg        cnv_meta_reg;
  reg        cnv_sync_reg;
  reg        cnv_prev_reg;
  reg        cmp_meta_reg;
  reg        cmp_sync_reg;
  wire       cnv_rise;

  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cnv_meta_reg <= 1'b0;
      cnv_sync_reg <= 1'b0;
      cnv_prev_reg <= 1'b0;
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
    end else begin
      cnv_meta_reg <= CONVERT_START_INPUT_IN;
      cnv_sync_reg <= cnv_meta_reg;
      cnv_prev_reg <= cnv_sync_reg;
      cmp_meta_reg <= COMPARATOR_IN;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  assign cnv_rise = cnv_sync_reg & ~cnv_prev_reg;

  // --------------------------------------------------------------------
  // Sequencer state.
  // --------------------------------------------------------------------
  localparam ST_ACQ    = `SCS_ST_ACQ;
  localparam ST_OPEN   = `SCS_ST_OPEN;
  localparam ST_HOLD   = `SCS_ST_HOLD;
  localparam ST_TRIAL  = `SCS_ST_TRIAL;
  localparam ST_DECIDE = `SCS_ST_DECIDE;
  localparam ST_DONE   = `SCS_ST_DONE;
  localparam ST_SETTLE = `SCS_ST_SETTLE;
  localparam [15:0] PERIOD = `SCS_PERIOD_CYC;

  reg  [2:0]       state_reg;
  reg  [2:0]       state_next;
  reg  [3:0]       bit_reg;
  reg  [3:0]       bit_next;
  reg  [WIDTH-1:0] code_reg;
  reg  [WIDTH-1:0] code_next;
  reg  [15:0]      gap_reg;
  wire [WIDTH-1:0] bit_mask;

  assign bit_mask = {{(WIDTH-1){1'b0}}, 1'b1} << bit_reg;

  always @* begin
    state_next = state_reg;
    bit_next   = bit_reg;
    code_next  = code_reg;
    case (state_reg)
      ST_ACQ: begin
        if (cnv_rise) begin
          state_next = ST_OPEN;
        end
      end
      ST_OPEN: begin
        state_next = ST_HOLD;
      end
      ST_HOLD: begin
        state_next = ST_TRIAL;
        bit_next   = `SCS_MSB_POS;
        code_next  = `SCS_CODE_MID;
      end
      ST_TRIAL: begin
        state_next = ST_SETTLE;
      end
      ST_SETTLE: begin
        // Waits for the comparator to cross both synchroniser stages.
        state_next = ST_DECIDE;
      end
      ST_DECIDE: begin
        // Comparator high means the trial overshot, so the bit clears.
        if (cmp_sync_reg) begin
          code_next = code_reg & ~bit_mask;
        end
        if (bit_reg == 4'h0) begin
          state_next = ST_DONE;
        end else begin
          bit_next   = bit_reg - 4'h1;
          code_next  = (cmp_sync_reg ? (code_reg & ~bit_mask) : code_reg)
                       | (bit_mask >> 1);
          state_next = ST_TRIAL;
        end
      end
      ST_DONE: begin
        state_next = ST_ACQ;
      end
      default: begin
        state_next = ST_ACQ;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Sequencer registers.
  // --------------------------------------------------------------------
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg <= ST_ACQ;
      bit_reg   <= 4'h0;
      code_reg  <= `SCS_CODE_ZERO;
    end else begin
      state_reg <= state_next;
      bit_reg   <= bit_next;
      code_reg  <= code_next;
    end
  end

  // --------------------------------------------------------------------
  // Conversion spacing monitor.
  // --------------------------------------------------------------------
  wire start_take;
  wire gap_short;

  assign start_take = (state_reg == ST_ACQ) && cnv_rise;
  assign gap_short  = (gap_reg != 16'h0000) && (gap_reg < PERIOD);

  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      gap_reg            <= 16'h0000;
      RATE_VIOLATION_OUT <= 1'b0;
    end else begin
      if (start_take) begin
        gap_reg            <= 16'h0001;
        RATE_VIOLATION_OUT <= gap_short;
      end else if (gap_short) begin
        gap_reg <= gap_reg + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // Analog switch drivers.
  // --------------------------------------------------------------------
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      POSITIVE_ARRAY_GROUND_SWITCH_OUT <= 1'b1;
      NEGATIVE_ARRAY_GROUND_SWITCH_OUT <= 1'b1;
      ARRAY_TO_INPUT_OUT               <= 1'b1;
      POWER_UP_OUT                     <= 1'b0;
    end else begin
      POSITIVE_ARRAY_GROUND_SWITCH_OUT <= (state_next == ST_ACQ);
      NEGATIVE_ARRAY_GROUND_SWITCH_OUT <= (state_next == ST_ACQ);
      ARRAY_TO_INPUT_OUT <= (state_next == ST_ACQ) ||
                            (state_next == ST_OPEN);
      POWER_UP_OUT       <= (state_next != ST_ACQ);
    end
  end

  // --------------------------------------------------------------------
  // Trial pattern driver.
  // --------------------------------------------------------------------
  wire trial_on;

  assign trial_on = (state_next == ST_TRIAL) ||
                    (state_next == ST_SETTLE) ||
                    (state_next == ST_DECIDE);

  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      TRIAL_WEIGHTS_OUT <= `SCS_CODE_ZERO;
    end else if (trial_on) begin
      TRIAL_WEIGHTS_OUT <= code_next;
    end else begin
      TRIAL_WEIGHTS_OUT <= `SCS_CODE_ZERO;
    end
  end

  // --------------------------------------------------------------------
  // Completion and result.
  // --------------------------------------------------------------------
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      BUSY_OUT        <= 1'b0;
      DONE_STROBE_OUT <= 1'b0;
      RESULT_OUT      <= `SCS_CODE_ZERO;
    end else begin
      BUSY_OUT        <= (state_next != ST_ACQ);
      DONE_STROBE_OUT <= (state_reg == ST_DONE);
      if (state_reg == ST_DONE) begin
        RESULT_OUT <= code_reg;
      end
    end
  end

endmodule // scs_sequencer
